// ---- design/timer_consts.svh ----
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH

// ****************************************
// Register map
// ****************************************
`define ADDR_TIMER_B_MODE       16'hffb2
`define ADDR_TIMER_B_COUNT      16'hffb3
`define ADDR_INT_REQUEST        16'hffb4
`define ADDR_INT_ENABLE         16'hffb5
`define ADDR_EDGE_SELECT        16'hffb6

// ****************************************
// Field positions
// ****************************************
`define MODE_AUTO_RELOAD_BIT    7
`define MODE_RSVD_MSB           6
`define MODE_RSVD_LSB           3
`define MODE_CLKSEL_MSB         2
`define MODE_CLKSEL_LSB         0
`define IRQ_OVERFLOW_BIT        0
`define IRQ_PIN_BIT             1
`define EDGE_RISING_BIT         0

// ****************************************
// Reset values
// ****************************************
`define MODE_RESET              8'h78
`define MODE_RSVD_VALUE         4'hf
`define COUNT_RESET             8'h00
`define RELOAD_RESET            8'h00
`define COUNT_ALL_ONES          8'hff

// ****************************************
// Prescaler tap exponents, ratio is two to the power
// ****************************************
`define PRESCALE_WIDTH          13
`define DIV_EXP_8192            13
`define DIV_EXP_2048            11
`define DIV_EXP_512             9
`define DIV_EXP_256             8
`define DIV_EXP_64              6
`define DIV_EXP_16              4
`define DIV_EXP_4               2

`endif

// ---- design/timer_pkg.sv ----
package timer_pkg;

  typedef enum logic [2:0] {
    clk_div_8192   = 3'b000,
    clk_div_2048   = 3'b001,
    clk_div_512    = 3'b010,
    clk_div_256    = 3'b011,
    clk_div_64     = 3'b100,
    clk_div_16     = 3'b101,
    clk_div_4      = 3'b110,
    clk_ext_event  = 3'b111
  } clock_select_t;

  typedef logic [7:0] byte_t;

endpackage : timer_pkg

// ---- design/count_source_if.sv ----
`timescale 1ns/100ps
interface count_source_if;
  import timer_pkg::*;

  clock_select_t clock_select;
  logic          edge_rising;
  logic          internal_tick;
  logic          event_edge;

  modport prescaler_mp (
    input  clock_select,
    output internal_tick
  );

  modport event_mp (
    input  edge_rising,
    output event_edge
  );

  modport timer_mp (
    output clock_select,
    output edge_rising,
    input  internal_tick,
    input  event_edge
  );

endinterface : count_source_if

// ---- design/clock_prescaler.sv ----
`timescale 1ns/100ps
`include "timer_consts.svh"
module clock_prescaler
  import timer_pkg::*;
(
  input wire logic          clock,
  input wire logic          rst,
  count_source_if.prescaler_mp src
);

  function automatic int div_exp(input int idx);
    case (idx)
      0:       div_exp = `DIV_EXP_8192;
      1:       div_exp = `DIV_EXP_2048;
      2:       div_exp = `DIV_EXP_512;
      3:       div_exp = `DIV_EXP_256;
      4:       div_exp = `DIV_EXP_64;
      5:       div_exp = `DIV_EXP_16;
      default: div_exp = `DIV_EXP_4;
    endcase
  endfunction : div_exp

  logic [`PRESCALE_WIDTH-1:0] div_cnt_ff;
  logic [7:0]                 tap;
  logic                       tick_ff;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) div_cnt_ff <= '0;
    else     div_cnt_ff <= div_cnt_ff + 1'b1;
  end

  // Each tap pulses once per ratio cycles.
  for (genvar i = 0; i < 7; i++) begin : g_tap
    localparam int E = div_exp(i);
    assign tap[i] = &div_cnt_ff[E-1:0];
  end

  // Code 111 has no tap; keeping the slot keeps every select code in range.
  assign tap[7] = 1'b0;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) tick_ff <= 1'b0;
    else     tick_ff <= (src.clock_select != clk_ext_event) && tap[src.clock_select];
  end

  assign src.internal_tick = tick_ff;

endmodule : clock_prescaler

// ---- design/event_edge_detect.sv ----
`timescale 1ns/100ps
module event_edge_detect
  import timer_pkg::*;
(
  input wire logic          clock,
  input wire logic          rst,
  input wire logic          pin,
  count_source_if.event_mp  evt
);

  logic sync1_ff;
  logic sync2_ff;
  logic sync3_ff;
  logic level_ff;
  logic edge_ff;
  logic nxt_level;

  // ****************************************
  // Synchroniser
  // ****************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      sync3_ff <= 1'b0;
    end else begin
      sync1_ff <= pin;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  // A level is accepted only when two stages agree, so a pin caught mid-change counts once.
  assign nxt_level = (sync2_ff == sync3_ff) ? sync3_ff : level_ff;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) level_ff <= 1'b0;
    else     level_ff <= nxt_level;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) edge_ff <= 1'b0;
    else     edge_ff <= (nxt_level != level_ff) && (nxt_level == evt.edge_rising);
  end

  assign evt.event_edge = edge_ff;

endmodule : event_edge_detect

// ---- design/reload_interval_timer_8bit.sv ----
// Contract
// - Mode register top bit: 0 interval counting, 1 auto-reload counting.
// - Mode bits 6 to 3 always read 1; writes to them ignored.
// - Seven internal count clocks: divide by 8192, 2048, 512, 256, 64, 16, 4.
// - Clock select 111 counts edges on the event input pin.
// - Edge select bit chooses rising or falling event edges.
// - Counter is 8-bit up-counter, readable anytime, never written directly.
// - Count clock after all ones sets the overflow flag, either mode.
// - Counter and reload share one address: read counter, write reload.
// - Writing reload also copies value into counter, counting continues upward.
// - Auto-reload overflow loads reload value, period 1 to 256 clocks.
// - Reset: mode 0x78, counter and reload zero, counting starts immediately.
// - Interval mode wraps all ones to zero and keeps counting.
// - Overflow interrupt raised only while its enable bit is 1.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/100ps
`include "timer_consts.svh"
module reload_interval_timer_8bit
  import timer_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wr_data,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output wire logic [7:0]  rd_data,
  input  wire logic        event_input_pin,
  output wire logic        irq
);

  // ****************************************
  // Declarations
  // ****************************************
  count_source_if src_if ();

  logic          auto_reload_select_ff;
  clock_select_t clock_select_ff;
  byte_t         timer_b_count_ff;
  byte_t         timer_b_reload_ff;
  byte_t         nxt_count;
  logic          overflow_request_flag_ff;
  logic          pin_request_flag_ff;
  logic          overflow_irq_enable_ff;
  logic          pin_interrupt_enable_ff;
  logic          event_edge_select_ff;
  byte_t         rd_data_ff;
  byte_t         nxt_rd_data;
  logic          irq_ff;
  logic          count_tick;
  logic          overflow;
  logic          wr_mode;
  logic          wr_count;
  logic          wr_req;
  logic          wr_ena;
  logic          wr_edge;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] target);
    hit = (a == target);
  endfunction : hit

  // ****************************************
  // Count sources
  // ****************************************
  assign src_if.clock_select = clock_select_ff;
  assign src_if.edge_rising  = event_edge_select_ff;

  clock_prescaler u_prescaler (
    .clock (clock),
    .rst   (rst),
    .src   (src_if.prescaler_mp)
  );

  event_edge_detect u_event (
    .clock (clock),
    .rst   (rst),
    .pin   (event_input_pin),
    .evt   (src_if.event_mp)
  );

  // The pin edge always feeds the pin interrupt flag, which is why software
  // should mask that interrupt while the pin is used for counting.
  always_comb begin
    if (clock_select_ff == clk_ext_event) begin
      count_tick = src_if.event_edge;
    end else begin
      count_tick = src_if.internal_tick;
    end
  end

  // ****************************************
  // Write decode
  // ****************************************
  assign wr_mode  = wr_en && hit(addr, `ADDR_TIMER_B_MODE);
  assign wr_count = wr_en && hit(addr, `ADDR_TIMER_B_COUNT);
  assign wr_req   = wr_en && hit(addr, `ADDR_INT_REQUEST);
  assign wr_ena   = wr_en && hit(addr, `ADDR_INT_ENABLE);
  assign wr_edge  = wr_en && hit(addr, `ADDR_EDGE_SELECT);

  // ****************************************
  // Mode register
  // ****************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      auto_reload_select_ff <= 1'(`MODE_RESET >> `MODE_AUTO_RELOAD_BIT);
      clock_select_ff       <= clk_div_8192;
    end else if (wr_mode) begin
      auto_reload_select_ff <= wr_data[`MODE_AUTO_RELOAD_BIT];
      clock_select_ff       <= clock_select_t'(wr_data[`MODE_CLKSEL_MSB:`MODE_CLKSEL_LSB]);
    end
  end

  // ****************************************
  // Reload register
  // ****************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      timer_b_reload_ff <= `RELOAD_RESET;
    end else if (wr_count) begin
      timer_b_reload_ff <= wr_data;
    end
  end

  // ****************************************
  // Counter
  // ****************************************
  assign overflow = count_tick && (timer_b_count_ff == `COUNT_ALL_ONES);

  // A software load beats a coincident count clock, so the written value is
  // always the one the counter starts from.
  always_comb begin
    nxt_count = timer_b_count_ff;
    if (wr_count) begin
      nxt_count = wr_data;
    end else if (overflow) begin
      if (auto_reload_select_ff) begin
        nxt_count = timer_b_reload_ff;
      end else begin
        nxt_count = `COUNT_RESET;
      end
    end else if (count_tick) begin
      nxt_count = timer_b_count_ff + 8'h01;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      timer_b_count_ff <= `COUNT_RESET;
    end else begin
      timer_b_count_ff <= nxt_count;
    end
  end

  // ****************************************
  // Interrupt request flags
  // ****************************************
  // A set in the same cycle as a write-one clear wins, so no event is lost.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      overflow_request_flag_ff <= 1'b0;
    end else if (overflow) begin
      overflow_request_flag_ff <= 1'b1;
    end else if (wr_req && wr_data[`IRQ_OVERFLOW_BIT]) begin
      overflow_request_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_request_flag_ff <= 1'b0;
    end else if (src_if.event_edge) begin
      pin_request_flag_ff <= 1'b1;
    end else if (wr_req && wr_data[`IRQ_PIN_BIT]) begin
      pin_request_flag_ff <= 1'b0;
    end
  end

  // ****************************************
  // Interrupt enables and edge select
  // ****************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      overflow_irq_enable_ff  <= 1'b0;
      pin_interrupt_enable_ff <= 1'b0;
    end else if (wr_ena) begin
      overflow_irq_enable_ff  <= wr_data[`IRQ_OVERFLOW_BIT];
      pin_interrupt_enable_ff <= wr_data[`IRQ_PIN_BIT];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      event_edge_select_ff <= 1'b0;
    end else if (wr_edge) begin
      event_edge_select_ff <= wr_data[`EDGE_RISING_BIT];
    end
  end

  // Registered so the output comes from a flip-flop; this costs one cycle of
  // latency after the flag sets.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= (overflow_request_flag_ff && overflow_irq_enable_ff) ||
                (pin_request_flag_ff && pin_interrupt_enable_ff);
    end
  end

  assign irq = irq_ff;

  // ****************************************
  // Read path
  // ****************************************
  always_comb begin
    nxt_rd_data = 8'h00;
    if (rd_en) begin
      if (hit(addr, `ADDR_TIMER_B_MODE)) begin
        nxt_rd_data = {auto_reload_select_ff, `MODE_RSVD_VALUE, clock_select_ff};
      end else if (hit(addr, `ADDR_TIMER_B_COUNT)) begin
        nxt_rd_data = timer_b_count_ff;
      end else if (hit(addr, `ADDR_INT_REQUEST)) begin
        nxt_rd_data = {6'h00, pin_request_flag_ff, overflow_request_flag_ff};
      end else if (hit(addr, `ADDR_INT_ENABLE)) begin
        nxt_rd_data = {6'h00, pin_interrupt_enable_ff, overflow_irq_enable_ff};
      end else if (hit(addr, `ADDR_EDGE_SELECT)) begin
        nxt_rd_data = {7'h00, event_edge_select_ff};
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_data_ff <= 8'h00;
    end else begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  assign rd_data = rd_data_ff;

endmodule : reload_interval_timer_8bit

// ---- test/timer_checker.sv ----
`timescale 1ns/100ps
module timer_checker
  import timer_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst,
  input wire logic [15:0] addr,
  input wire logic [7:0]  wr_data,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [7:0]  rd_data,
  input wire logic        event_input_pin,
  input wire logic        irq
);
  // ****************************************
  // Shadows of what software wrote.
  // ****************************************
  byte_t      mode_ff;
  logic [1:0] en_ff;
  logic       pin_ff;
  logic [3:0] quiet_ff;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_ff <= 8'h78;
    end else if (wr_en && addr == 16'hffb2) begin
      mode_ff <= {wr_data[7], 4'hf, wr_data[2:0]};
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      en_ff <= 2'h0;
    end else if (wr_en && addr == 16'hffb5) begin
      en_ff <= wr_data[1:0];
    end
  end

  // Events still in the synchroniser may move the count, so wait well past them.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_ff   <= 1'b0;
      quiet_ff <= 4'h0;
    end else begin
      pin_ff <= event_input_pin;
      if (pin_ff != event_input_pin || (wr_en && addr == 16'hffb2)) begin
        quiet_ff <= 4'h0;
      end else if (quiet_ff != 4'hf) begin
        quiet_ff <= quiet_ff + 4'h1;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // ****************************************
  // Properties.
  // ****************************************
  property p_rd_idle; !rd_en |=> rd_data == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
  property p_mode_read; rd_en && addr == 16'hffb2 |=> rd_data == $past(mode_ff); endproperty
  a_mode_read: assert property (p_mode_read) else $error("mode readback wrong");
  property p_rsvd; rd_en && addr == 16'hffb2 |=> rd_data[6:3] == 4'hf; endproperty
  a_rsvd: assert property (p_rsvd) else $error("mode bits 6 to 3 not ones");
  property p_unmapped;
    rd_en && !(addr inside {[16'hffb2:16'hffb6]}) |=> rd_data == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_load_rb;
    wr_en && addr == 16'hffb3 ##1 rd_en && addr == 16'hffb3 |=> rd_data == $past(wr_data, 2);
  endproperty
  a_load_rb: assert property (p_load_rb) else $error("load not copied to count");
  property p_irq_en; irq |-> $past(en_ff[0]) || $past(en_ff[1]); endproperty
  a_irq_en: assert property (p_irq_en) else $error("irq without enable");
  property p_irq_off; wr_en && addr == 16'hffb5 && wr_data[1:0] == 2'b00 |=> ##1 !irq; endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq after disable");
  sequence s_static;
    rd_en && addr == 16'hffb3 && mode_ff[2:0] == 3'h7 && quiet_ff > 4'h7 ##1 !wr_en
      ##1 rd_en && addr == 16'hffb3 && quiet_ff > 4'h7;
  endsequence
  property p_static; s_static |=> rd_data == $past(rd_data, 2); endproperty
  a_static: assert property (p_static) else $error("count moved without event");

  c_irq: cover property ($rose(irq));
  c_static: cover property (s_static);
  c_load: cover property (wr_en && addr == 16'hffb3 ##1 rd_en && addr == 16'hffb3);
endmodule : timer_checker

bind reload_interval_timer_8bit timer_checker u_timer_checker (
  .clock(clock), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
  .rd_data(rd_data), .event_input_pin(event_input_pin), .irq(irq)
);

// ---- test/event_source.sv ----
`timescale 1ns/100ps
module event_source (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       go,
  input  wire logic [3:0] n_pulses,
  output logic            pin,
  output logic            busy
);
  // ****************************************
  // Pulse train, six cycles high and six low.
  // ****************************************
  logic [3:0] left_ff;
  logic [2:0] ph_ff;

  assign busy = left_ff != 4'h0;

  // The pin rests low between trains, so every pulse gives one edge of each kind.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin     <= 1'b0;
      left_ff <= 4'h0;
      ph_ff   <= 3'h0;
    end else if (go && !busy) begin
      left_ff <= n_pulses;
      ph_ff   <= 3'h0;
    end else if (busy) begin
      ph_ff <= ph_ff + 3'h1;
      if (ph_ff == 3'h5) begin
        ph_ff <= 3'h0;
        pin   <= !pin;
        if (pin) begin
          left_ff <= left_ff - 4'h1;
        end
      end
    end
  end
endmodule : event_source

// ---- test/tb_reload_interval_timer_8bit.sv ----
`timescale 1ns/100ps
module tb_reload_interval_timer_8bit;
  import timer_pkg::*;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] addr = 16'h0000;
  byte_t       wr_data = 8'h00;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  byte_t       rd_data;
  logic        pin;
  logic        irq;
  logic        go = 1'b0;
  logic [3:0]  n_pulses = 4'h0;
  logic        busy;
  int          n_errors = 0;
  int          n_tests = 0;
  byte_t       v;
  int          div [7] = '{8192, 2048, 512, 256, 64, 16, 4};

  always #20 clock = ~clock;

  reload_interval_timer_8bit u_reload_interval_timer_8bit (
    .clock(clock), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .event_input_pin(pin), .irq(irq)
  );
  event_source u_event_source (
    .clock(clock), .rst(rst), .go(go), .n_pulses(n_pulses), .pin(pin), .busy(busy)
  );

  // ****************************************
  // Bus and compare tasks.
  // ****************************************
  task automatic stop_test();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  task automatic chk_byte(input byte_t got, input byte_t exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  // Strobes are left high so that writes may follow each other with no gap.
  task automatic wr(input logic [15:0] a, input byte_t d);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    rd_en <= 1'b0;
    @(posedge clock);
  endtask : wr

  task automatic rd(input logic [15:0] a, output byte_t d);
    addr <= a;
    rd_en <= 1'b1;
    wr_en <= 1'b0;
    @(posedge clock);
    rd_en <= 1'b0;
    @(negedge clock);
    d = rd_data;
    @(posedge clock);
  endtask : rd

  task automatic rd_chk(input logic [15:0] a, input byte_t exp);
    byte_t d;
    rd(a, d);
    chk_byte(d, exp);
  endtask : rd_chk

  task automatic idle(input int n);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    repeat (n) @(posedge clock);
  endtask : idle

  task automatic events(input logic [3:0] n);
    int i;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    go <= 1'b1;
    n_pulses <= n;
    @(posedge clock);
    go <= 1'b0;
    for (i = 0; i < 200 && (i == 0 || busy !== 1'b0); i++) @(posedge clock);
    chk_bit(busy, 1'b0);
    if (busy !== 1'b0) stop_test();
    repeat (10) @(posedge clock);
  endtask : events

  // ****************************************
  // Scenarios.
  // ****************************************
  task automatic t_reset();
    rd_chk(16'hffb2, 8'h78);
    rd_chk(16'hffb3, 8'h00);
    rd_chk(16'hffb7, 8'h00);
  endtask : t_reset

  task automatic t_event();
    wr(16'hffb2, 8'h07);
    rd_chk(16'hffb2, 8'h7f);
    wr(16'hffb6, 8'h01);
    rd_chk(16'hffb6, 8'h01);
    wr(16'hffb3, 8'hfe);
    rd_chk(16'hffb3, 8'hfe);
    events(4'h2);
    rd_chk(16'hffb3, 8'h00);
    rd_chk(16'hffb3, 8'h00);
    rd_chk(16'hffb4, 8'h03);
    wr(16'hffb4, 8'h03);
    rd_chk(16'hffb4, 8'h00);
    wr(16'hffb6, 8'h00);
    wr(16'hffb3, 8'h10);
    events(4'h3);
    rd_chk(16'hffb3, 8'h13);
  endtask : t_event

  task automatic t_reload();
    wr(16'hffb2, 8'h87);
    rd_chk(16'hffb2, 8'hff);
    wr(16'hffb3, 8'hfd);
    events(4'h4);
    rd_chk(16'hffb3, 8'hfe);
  endtask : t_reload

  task automatic t_irq();
    chk_bit(irq, 1'b0);
    wr(16'hffb5, 8'h01);
    rd_chk(16'hffb5, 8'h01);
    idle(1);
    chk_bit(irq, 1'b1);
    wr(16'hffb5, 8'h00);
    idle(2);
    chk_bit(irq, 1'b0);
    wr(16'hffb4, 8'h03);
    wr(16'hffb5, 8'h01);
    idle(2);
    chk_bit(irq, 1'b0);
    wr(16'hffb5, 8'h00);
    idle(2);
  endtask : t_irq

  task automatic t_divide();
    int i;
    for (i = 0; i < 7; i++) begin
      wr(16'hffb2, byte_t'(i));
      wr(16'hffb3, 8'h00);
      idle(5 * div[i]);
      rd(16'hffb3, v);
      chk_bit(v inside {8'h05, 8'h06}, 1'b1);
    end
  endtask : t_divide

  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_reset();
    t_event();
    t_reload();
    t_irq();
    t_divide();
    stop_test();
  end
endmodule : tb_reload_interval_timer_8bit
